// *** inc/smc_pkg.sv ***
// Package for the standby mode control block: register layout, reset value, wait counts.
// Assumes a 16-bit control register reached through the core-side interface.
package smc_pkg;
  // ----------------------------------------------------------------
  // Register layout
  // ----------------------------------------------------------------
  localparam int unsigned SMC_STBY_SEL_POS = 15;
  localparam int unsigned SMC_RSV_ONE_POS = 14;
  localparam int unsigned SMC_RSV_ZERO_POS = 13;
  localparam int unsigned SMC_WAIT_SEL_HI = 12;
  localparam int unsigned SMC_WAIT_SEL_LO = 8;
  localparam logic [15:0] SMC_CTRL_RESET = 16'h4f00;
  localparam logic [15:0] SMC_CTRL_WMASK = 16'h9f00;
  localparam logic [15:0] SMC_CTRL_ONES = 16'h4000;
  // Software-side port addresses
  localparam logic [1:0] SMC_ADDR_CTRL = 2'h0;
  localparam logic [1:0] SMC_ADDR_STAT = 2'h1;
  // ----------------------------------------------------------------
  // Wait counts in peripheral-clock states
  // ----------------------------------------------------------------
  localparam int unsigned SMC_CNT_W = 20;
  localparam logic [4:0] SMC_WSEL_FIRST = 5'h05;
  localparam logic [4:0] SMC_WSEL_LAST = 5'h0f;
  localparam logic [19:0] SMC_WAIT_05 = 20'h00040;
  localparam logic [19:0] SMC_WAIT_06 = 20'h00200;
  localparam logic [19:0] SMC_WAIT_07 = 20'h00400;
  localparam logic [19:0] SMC_WAIT_08 = 20'h00800;
  localparam logic [19:0] SMC_WAIT_09 = 20'h01000;
  localparam logic [19:0] SMC_WAIT_0A = 20'h04000;
  localparam logic [19:0] SMC_WAIT_0B = 20'h08000;
  localparam logic [19:0] SMC_WAIT_0C = 20'h10000;
  localparam logic [19:0] SMC_WAIT_0D = 20'h20000;
  localparam logic [19:0] SMC_WAIT_0E = 20'h40000;
  localparam logic [19:0] SMC_WAIT_0F = 20'h80000;
  // Low-power mode codes
  localparam logic [1:0] SMC_MODE_RUN = 2'h0;
  localparam logic [1:0] SMC_MODE_SLEEP = 2'h1;
  localparam logic [1:0] SMC_MODE_CLKSTOP = 2'h2;
  localparam logic [1:0] SMC_MODE_STANDBY = 2'h3;
endpackage : smc_pkg

// *** inc/smc_if.sv ***
// Interface joining the processor-core end and the standby controller end.
// Assumes both ends share i_sys_clk; all signals are single-cycle synchronous.
`timescale 1ns/10ps
interface smc_if;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic sleep_req;
  logic ext_irq;
  logic any_irq;
  logic pclk_en;
  logic watchdog_mode;
  logic clkstop_en;
  logic [1:0] mode;
  logic clocks_run;
  modport ctrl (
    input reg_wr, reg_rd, reg_wdata, sleep_req, ext_irq, any_irq, pclk_en,
    input watchdog_mode, clkstop_en,
    output reg_rdata, mode, clocks_run
  );
  modport core (
    output reg_wr, reg_rd, reg_wdata, sleep_req, ext_irq, any_irq, pclk_en,
    output watchdog_mode, clkstop_en,
    input reg_rdata, mode, clocks_run
  );
endinterface : smc_if

// *** core/smc_ctrl.sv ***
// Standby mode controller: control register, mode choice on sleep, settling wait.
// Assumes the core end drives one-cycle strobes on i_sys_clk and a peripheral enable.
//
// Operation
// - Bit 15 picks the low-power state
// - Clear gives sleep, set gives standby
// - Wake-up leaves bit 15 untouched
// - Software writes zero to select sleep again; only an external interrupt leaves standby
// - Watchdog mode forbids standby on sleep
// - Bit 14 reads one always
// - Bit 13 reads zero always
// - Bits 12..8 choose settling wait length
// - Wait counter steps on peripheral clock
// - Codes 5..7 give 64, 512, 1024
// - Software covers crystal settling time
// - Software covers multiplier loop settling
// - Codes 8..15 give 2048 up to 524288
`timescale 1ns/10ps
module smc_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  smc_if.ctrl bus
);
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_STBY = 4'h4,
    ST_SETTLE = 4'h8
  } smc_state_type;

  smc_state_type state_q;
  logic [15:0] ctrl_q;
  logic [15:0] rdata_q;
  logic [19:0] cnt_q;
  logic [19:0] wait_len;
  logic [1:0] mode_q;
  logic run_q;
  logic [4:0] wsel;

  assign wsel = ctrl_q[smc_pkg::SMC_WAIT_SEL_HI:smc_pkg::SMC_WAIT_SEL_LO];

  // ----------------------------------------------------------------
  // Wait length lookup
  // ----------------------------------------------------------------
  always_comb begin
    unique case (wsel)
      5'h05: wait_len = smc_pkg::SMC_WAIT_05;
      5'h06: wait_len = smc_pkg::SMC_WAIT_06;
      5'h07: wait_len = smc_pkg::SMC_WAIT_07;
      5'h08: wait_len = smc_pkg::SMC_WAIT_08;
      5'h09: wait_len = smc_pkg::SMC_WAIT_09;
      5'h0a: wait_len = smc_pkg::SMC_WAIT_0A;
      5'h0b: wait_len = smc_pkg::SMC_WAIT_0B;
      5'h0c: wait_len = smc_pkg::SMC_WAIT_0C;
      5'h0d: wait_len = smc_pkg::SMC_WAIT_0D;
      5'h0e: wait_len = smc_pkg::SMC_WAIT_0E;
      5'h0f: wait_len = smc_pkg::SMC_WAIT_0F;
      // Reserved codes fall back to the longest wait
      default: wait_len = smc_pkg::SMC_WAIT_0F;
    endcase
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= smc_pkg::SMC_CTRL_RESET;
    end else if (bus.reg_wr) begin
      // Bit 14 forced high, bit 13 and low byte forced low; wake never touches 15
      ctrl_q <= (bus.reg_wdata & smc_pkg::SMC_CTRL_WMASK) | smc_pkg::SMC_CTRL_ONES;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 16'h0000;
    end else if (bus.reg_rd) begin
      rdata_q <= ctrl_q | smc_pkg::SMC_CTRL_ONES;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_RUN;
      mode_q <= smc_pkg::SMC_MODE_RUN;
      run_q <= 1'b1;
      cnt_q <= 20'h00000;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (bus.sleep_req) begin
            run_q <= 1'b0;
            if (ctrl_q[smc_pkg::SMC_STBY_SEL_POS] && !bus.watchdog_mode) begin
              state_q <= ST_STBY;
              mode_q <= smc_pkg::SMC_MODE_STANDBY;
            end else begin
              state_q <= ST_SLEEP;
              mode_q <= bus.clkstop_en ? smc_pkg::SMC_MODE_CLKSTOP : smc_pkg::SMC_MODE_SLEEP;
            end
          end
        end
        ST_SLEEP: begin
          if (bus.any_irq) begin
            state_q <= ST_RUN;
            mode_q <= smc_pkg::SMC_MODE_RUN;
            run_q <= 1'b1;
          end
        end
        ST_STBY: begin
          if (bus.ext_irq) begin
            state_q <= ST_SETTLE;
            cnt_q <= wait_len;
          end
        end
        ST_SETTLE: begin
          if (bus.pclk_en) begin
            if (cnt_q == 20'h00001) begin
              state_q <= ST_RUN;
              mode_q <= smc_pkg::SMC_MODE_RUN;
              run_q <= 1'b1;
              cnt_q <= 20'h00000;
            end else begin
              cnt_q <= cnt_q - 20'h00001;
            end
          end
        end
      endcase
    end
  end

  assign bus.reg_rdata = rdata_q;
  assign bus.mode = mode_q;
  assign bus.clocks_run = run_q;
endmodule : smc_ctrl

// *** core/smc_core.sv ***
// Processor-core end: turns user requests into register strobes and sleep requests.
// Assumes user strobes are one cycle on i_sys_clk; pins are already synchronous.
`timescale 1ns/10ps
module smc_core (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_wdata,
  input wire logic i_sleep,
  input wire logic i_ext_irq,
  input wire logic i_int_irq,
  input wire logic i_watchdog_mode,
  input wire logic i_clkstop_en,
  input wire logic [1:0] i_pclk_div,
  output logic [15:0] o_rdata,
  output logic [1:0] o_mode,
  output logic o_running,
  smc_if.core bus
);
  logic [2:0] div_q;
  logic pen_q;
  logic wr_q;
  logic rd_q;
  logic slp_q;
  logic eirq_q;
  logic airq_q;
  logic [15:0] wdata_q;

  // ----------------------------------------------------------------
  // Peripheral clock enable divider
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_q <= 3'h0;
      pen_q <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      unique case (i_pclk_div)
        2'h0: pen_q <= 1'b1;
        2'h1: pen_q <= div_q[0];
        2'h2: pen_q <= &div_q[1:0];
        2'h3: pen_q <= &div_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request stage; field reserved bits written as documented
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      slp_q <= 1'b0;
      eirq_q <= 1'b0;
      airq_q <= 1'b0;
      wdata_q <= 16'h0000;
    end else begin
      wr_q <= i_wr;
      rd_q <= i_rd && !i_wr;
      slp_q <= i_sleep && bus.clocks_run;
      eirq_q <= i_ext_irq;
      airq_q <= i_ext_irq || i_int_irq;
      wdata_q <= (i_wdata & smc_pkg::SMC_CTRL_WMASK) | smc_pkg::SMC_CTRL_ONES;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 16'h0000;
      o_mode <= smc_pkg::SMC_MODE_RUN;
      o_running <= 1'b1;
    end else begin
      o_rdata <= bus.reg_rdata;
      o_mode <= bus.mode;
      o_running <= bus.clocks_run;
    end
  end

  assign bus.reg_wr = wr_q;
  assign bus.reg_rd = rd_q;
  assign bus.reg_wdata = wdata_q;
  assign bus.sleep_req = slp_q;
  assign bus.ext_irq = eirq_q;
  assign bus.any_irq = airq_q;
  assign bus.pclk_en = pen_q;
  assign bus.watchdog_mode = i_watchdog_mode;
  assign bus.clkstop_en = i_clkstop_en;
endmodule : smc_core

// *** tb/smc_sva.sv ***
// Checker for the signals between the core end and the standby controller.
// Assumes one clock domain; instantiated beside the interface in the test top.
`timescale 1ns/10ps
module smc_sva (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic sleep_req,
  input wire logic ext_irq,
  input wire logic pclk_en,
  input wire logic watchdog_mode,
  input wire logic clkstop_en,
  input wire logic [1:0] mode,
  input wire logic clocks_run
);
  logic [15:0] shadow_q;
  logic irq_q;
  int pc_q;
  int wlen;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // ------------------------------------------------
  // Register shadow and settle pulse count
  // ------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shadow_q <= smc_pkg::SMC_CTRL_RESET;
      irq_q <= 1'b0;
      pc_q <= 0;
    end else begin
      if (reg_wr) shadow_q <= (reg_wdata & smc_pkg::SMC_CTRL_WMASK) | smc_pkg::SMC_CTRL_ONES;
      irq_q <= clocks_run ? 1'b0 : (irq_q | (ext_irq && mode == smc_pkg::SMC_MODE_STANDBY));
      pc_q <= clocks_run ? 0 : pc_q + int'(irq_q && pclk_en);
    end
  end
  // Settle length in peripheral steps for the programmed code
  always_comb begin
    case (shadow_q[12:8])
      5'h05: wlen = 64;
      5'h06: wlen = 512;
      5'h07: wlen = 1024;
      5'h08: wlen = 2048;
      5'h09: wlen = 4096;
      5'h0a: wlen = 16384;
      5'h0b: wlen = 32768;
      5'h0c: wlen = 65536;
      5'h0d: wlen = 131072;
      5'h0e: wlen = 262144;
      default: wlen = 524288;
    endcase
  end
  sequence s_sleep_taken;
    sleep_req && clocks_run && mode == smc_pkg::SMC_MODE_RUN && !reg_wr;
  endsequence
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  a_enter_sleep: assert property (s_sleep_taken ##0 (!shadow_q[15] && !clkstop_en)
    |=> mode == smc_pkg::SMC_MODE_SLEEP) else $error("sleep not entered");
  a_enter_standby: assert property (s_sleep_taken ##0 (shadow_q[15] && !watchdog_mode)
    |=> mode == smc_pkg::SMC_MODE_STANDBY && !clocks_run) else $error("standby not entered");
  a_watchdog_blocks: assert property (s_sleep_taken ##0 watchdog_mode
    |=> mode != smc_pkg::SMC_MODE_STANDBY) else $error("standby under watchdog");
  a_read_shadow: assert property ($past(reg_rd) |-> reg_rdata == shadow_q)
    else $error("register read mismatch");
  a_bit14_one: assert property ($past(reg_rd) |-> reg_rdata[14])
    else $error("bit 14 read as zero");
  a_bit13_zero: assert property ($past(reg_rd) |-> !reg_rdata[13])
    else $error("bit 13 read as one");
  a_settle_count: assert property ($rose(clocks_run) && irq_q
    |-> pc_q inside {[wlen - 2 : wlen + 2]}) else $error("settle length wrong");
  a_pclk_step: assert property ($rose(clocks_run) && irq_q
    |-> $past(pclk_en) || $past(pclk_en, 2)) else $error("restart off peripheral step");
  a_standby_holds: assert property (mode == smc_pkg::SMC_MODE_STANDBY && !irq_q
    && !ext_irq |=> !clocks_run) else $error("clocks restarted early");
endmodule : smc_sva

// *** tb/standby_mode_control_test.sv ***
// Self-checking test of both ends joined through the interface.
// Assumes the design files and package are compiled first.
`timescale 1ns/10ps
module standby_mode_control_test;
  logic i_sys_clk, i_resetn, i_wr, i_rd, i_sleep, i_ext_irq, i_int_irq;
  logic i_watchdog_mode, i_clkstop_en;
  logic [1:0] i_pclk_div, o_mode;
  logic [15:0] i_wdata, o_rdata;
  logic o_running;
  int n_fail, n_compared, seed, ctrl_m, n;
  smc_if bus_if();
  smc_ctrl smc_ctrl_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .bus(bus_if));
  smc_core smc_core_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_wr(i_wr),
    .i_rd(i_rd), .i_wdata(i_wdata), .i_sleep(i_sleep), .i_ext_irq(i_ext_irq),
    .i_int_irq(i_int_irq), .i_watchdog_mode(i_watchdog_mode), .i_clkstop_en(i_clkstop_en),
    .i_pclk_div(i_pclk_div), .o_rdata(o_rdata), .o_mode(o_mode), .o_running(o_running),
    .bus(bus_if));
  smc_sva smc_sva_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .reg_wr(bus_if.reg_wr),
    .reg_rd(bus_if.reg_rd), .reg_wdata(bus_if.reg_wdata), .reg_rdata(bus_if.reg_rdata),
    .sleep_req(bus_if.sleep_req), .ext_irq(bus_if.ext_irq), .pclk_en(bus_if.pclk_en),
    .watchdog_mode(bus_if.watchdog_mode), .clkstop_en(bus_if.clkstop_en),
    .mode(bus_if.mode), .clocks_run(bus_if.clocks_run));
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // ------------------------------------------------
  // Compare, bus and sequencing tasks
  // ------------------------------------------------
  task tally_and_finish;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task cmp_range(input string what, input int lo, input int hi, input int got);
    n_compared++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : cmp_range
  function automatic int wait_states(input logic [4:0] code);
    case (code)
      5'h05: return 64;
      5'h06: return 512;
      5'h07: return 1024;
      5'h08: return 2048;
      default: return 524288;
    endcase
  endfunction : wait_states
  task wr(input logic [15:0] d);
    @(posedge i_sys_clk) i_wr <= 1'b1;
    i_wdata <= d;
    @(posedge i_sys_clk) i_wr <= 1'b0;
    ctrl_m = (d & smc_pkg::SMC_CTRL_WMASK) | smc_pkg::SMC_CTRL_ONES;
  endtask : wr
  task rd_chk;
    @(posedge i_sys_clk) i_rd <= 1'b1;
    @(posedge i_sys_clk) i_rd <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1 cmp("read data", ctrl_m[15:0], o_rdata);
  endtask : rd_chk
  task pulse_sleep(input logic [1:0] m);
    @(posedge i_sys_clk) i_sleep <= 1'b1;
    @(posedge i_sys_clk) i_sleep <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    cmp("mode", {14'h0000, m}, {14'h0000, o_mode});
  endtask : pulse_sleep
  task wake_int;
    @(posedge i_sys_clk) i_int_irq <= 1'b1;
    @(posedge i_sys_clk) i_int_irq <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    cmp("mode after wake", {14'h0000, smc_pkg::SMC_MODE_RUN}, {14'h0000, o_mode});
  endtask : wake_int
  task standby(input logic [4:0] code, input logic [1:0] div);
    int exp;
    exp = wait_states(code) << div;
    i_pclk_div <= div;
    wr({3'h6, code, 8'h00});
    pulse_sleep(smc_pkg::SMC_MODE_STANDBY);
    cmp("running in standby", 16'h0000, {15'h0000, o_running});
    @(posedge i_sys_clk) i_ext_irq <= 1'b1;
    @(posedge i_sys_clk) i_ext_irq <= 1'b0;
    n = 1;
    while (o_running !== 1'b1 && n < 5000) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    cmp_range("settle cycles", exp, exp + 8, n);
    rd_chk;
  endtask : standby
  initial begin
    {i_wr, i_rd, i_sleep, i_ext_irq, i_int_irq, i_watchdog_mode, i_clkstop_en} = 7'h00;
    i_resetn = 1'b0;
    i_pclk_div = 2'h0;
    i_wdata = 16'h0000;
    n_fail = 0;
    n_compared = 0;
    seed = 32'h7836d306;
    ctrl_m = smc_pkg::SMC_CTRL_RESET;
    repeat (4) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rd_chk;
    wr(16'hffff);
    rd_chk;
    repeat (4) begin
      wr(16'(($random(seed) & 32'h00009f00) | 32'h00004000));
      rd_chk;
    end
    wr(16'h4500);
    pulse_sleep(smc_pkg::SMC_MODE_SLEEP);
    wake_int;
    i_clkstop_en <= 1'b1;
    pulse_sleep(smc_pkg::SMC_MODE_CLKSTOP);
    wake_int;
    i_clkstop_en <= 1'b0;
    i_watchdog_mode <= 1'b1;
    wr(16'hc500);
    pulse_sleep(smc_pkg::SMC_MODE_SLEEP);
    wake_int;
    i_watchdog_mode <= 1'b0;
    standby(5'h05, 2'h0);
    standby(5'h05, 2'h1);
    standby(5'h06, 2'h0);
    standby(5'h07, 2'h0);
    standby(5'h08, 2'h0);
    wr(16'h4500);
    pulse_sleep(smc_pkg::SMC_MODE_SLEEP);
    @(posedge i_sys_clk) i_resetn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    ctrl_m = smc_pkg::SMC_CTRL_RESET;
    rd_chk;
    cmp("mode after reset", 16'h0000, {14'h0000, o_mode});
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_fail++;
    tally_and_finish;
  end
endmodule : standby_mode_control_test
